// *** dce_params.svh ***
// Constants, register map and field positions of the compare event control.
// Assumes inclusion by bare name from the package and the modules.
// Contract
// - A2 force path select is bit 9.
// - A2 source raw or filtered, bit 8.
// - A1 sync pulse enabled by bit 3.
// - A1 conversion start enabled by bit 2.
// - A1 force path select is bit 1.
// - A1 source raw or filtered, bit 0.
// - B2 force path select is bit 9.
// - B2 source raw or filtered, bit 8.
// - B1 sync pulse enabled by bit 3.
// - B1 conversion start enabled by bit 2.
// - B1 force path select is bit 1.
// - B1 source raw or filtered, bit 0.
// - Alignment strobe: 00 period, 01 zero.
// - Filter bit 3 inverts blanking window.
// - Filter bit 2 enables blanking window.
// - Filter bits 1-0 choose filter source.
// - Shadow mode copies capture at strobe.
// - Active mode reads the live capture.
// - Capture bit 0 enables counter capture.
// - Capture first filtered rise per period.
// - Offset loads at strobe, counts down.
`ifndef DCE_PARAMS_SVH
`define DCE_PARAMS_SVH
`define DCE_ADDR_ACTL     12'h000
`define DCE_ADDR_BCTL     12'h004
`define DCE_ADDR_FCTL     12'h008
`define DCE_ADDR_CAPCTL   12'h00c
`define DCE_ADDR_CAP      12'h010
`define DCE_ADDR_OFFSET   12'h014
`define DCE_ADDR_OFFCNT   12'h018
`define DCE_ADDR_WINDOW   12'h01c
`define DCE_EV_MASK       16'h030f
`define DCE_FCTL_MASK     16'h003f
`define DCE_CAPCTL_MASK   16'h0003
`define DCE_B_SRC1        0
`define DCE_B_FRC1        1
`define DCE_B_SOC1        2
`define DCE_B_SYNC1       3
`define DCE_B_SRC2        8
`define DCE_B_FRC2        9
`define DCE_B_BLANK_EN    2
`define DCE_B_BLANK_INV   3
`define DCE_F_SRC_LO      0
`define DCE_F_SRC_HI      1
`define DCE_F_ALIGN_LO    4
`define DCE_F_ALIGN_HI    5
`define DCE_B_CAP_EN      0
`define DCE_B_SHDW        1
`define DCE_ALIGN_PRD     2'h0
`define DCE_ALIGN_ZERO    2'h1
`define DCE_RST16         16'h0000
`endif

// *** dce_pkg.sv ***
// Types shared by the compare event control modules.
// Assumes the params header is on the include path.
package dce_pkg;
  `include "dce_params.svh"
  typedef logic [15:0] dce_word_t;
  typedef enum logic [2:0] {
    DCE_IDLE  = 3'b001,
    DCE_COUNT = 3'b010,
    DCE_OPEN  = 3'b100
  } dce_blank_e;
endpackage

// *** dce_blank_win.sv ***
// Blanking window timer: offset countdown then a window of the programmed width plus one cycle.
// Assumes the alignment strobe is a one-cycle pulse on the module clock.
`timescale 1ns/1ns
`include "dce_params.svh"
module dce_blank_win
  import dce_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Control
  input  wire logic      align,
  input  wire dce_word_t offset,
  input  wire dce_word_t width,
  // State
  output logic           window,
  output dce_word_t      offset_count
);
  dce_blank_e state;
  dce_word_t  win_count;

  // Offset loads at each strobe, even mid-window, so the timer restarts.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state        <= DCE_IDLE;
      offset_count <= `DCE_RST16;
      win_count    <= `DCE_RST16;
    end
    else if (align)
    begin
      state        <= DCE_COUNT;
      offset_count <= offset;
      win_count    <= width;
    end
    else
    begin
      case (state)
        DCE_IDLE:
          state <= DCE_IDLE;
        DCE_COUNT:
          if (offset_count == `DCE_RST16)
            state <= DCE_OPEN;
          else
            offset_count <= offset_count - 16'h0001;
        DCE_OPEN:
          if (win_count == `DCE_RST16)
            state <= DCE_IDLE;
          else
            win_count <= win_count - 16'h0001;
        default:
          state <= DCE_IDLE;
      endcase
    end
  end

  // The window is a decode of state, so it opens the cycle after the count reaches zero.
  assign window = (state == DCE_OPEN);
endmodule

// *** dce_event_ctrl.sv ***
// Compare event control: event routing, filter, blanking and capture.
// Assumes APB3 master on MCLK; raw events and strobes come from the
// time-base logic on MCLK itself, so they are not resynchronised.
`timescale 1ns/1ns
`include "dce_params.svh"
module dce_event_ctrl
  import dce_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Raw compare events and time-base strobes
  input  wire logic        RAW_A1,
  input  wire logic        RAW_A2,
  input  wire logic        RAW_B1,
  input  wire logic        RAW_B2,
  input  wire logic        PRD_STROBE,
  input  wire logic        ZERO_STROBE,
  input  wire logic [15:0] TIME_BASE_COUNT,
  // Routed events
  output logic             COMPARE_A_EVENT_ONE,
  output logic             COMPARE_A_EVENT_TWO,
  output logic             COMPARE_B_EVENT_ONE,
  output logic             COMPARE_B_EVENT_TWO,
  output logic             A1_ASYNC_PATH,
  output logic             A2_ASYNC_PATH,
  output logic             B1_ASYNC_PATH,
  output logic             B2_ASYNC_PATH,
  output logic             FILTERED_EVENT,
  output logic             A1_SYNC_PULSE,
  output logic             A1_CONV_START,
  output logic             B1_SYNC_PULSE,
  output logic             B1_CONV_START
);
  dce_word_t a_ctl;
  dce_word_t b_ctl;
  dce_word_t f_ctl;
  dce_word_t cap_ctl;
  dce_word_t offset_reg;
  dce_word_t window_reg;
  dce_word_t cap_active;
  dce_word_t cap_shadow;
  dce_word_t offset_count;
  logic      cap_armed;
  logic      filt_prev;
  logic      align;
  logic      blank_win;
  logic      eff_win;
  logic      filt_src;
  logic      filt_evt;
  logic      next_a1;
  logic      next_a2;
  logic      next_b1;
  logic      next_b2;
  logic      wr_en;
  logic      rd_en;
  logic      addr_ok;
  logic      cap_rise;

  // Picks raw or filtered; shared by the four event outputs.
  function automatic logic pick(input logic sel, input logic raw,
                                input logic filt);
    pick = sel ? filt : raw;
  endfunction

  // Address decode used by both the write enable and the error answer.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `DCE_ADDR_ACTL) || (a == `DCE_ADDR_BCTL) ||
             (a == `DCE_ADDR_FCTL) || (a == `DCE_ADDR_CAPCTL) ||
             (a == `DCE_ADDR_CAP) || (a == `DCE_ADDR_OFFSET) ||
             (a == `DCE_ADDR_OFFCNT) || (a == `DCE_ADDR_WINDOW);
  endfunction

  // Zero-wait slave: every access completes in its first access cycle.
  assign addr_ok = mapped(PADDR);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign wr_en   = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_en   = PSEL && !PENABLE && !PWRITE;

  // Control registers; reserved bits are masked so they stay zero.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      a_ctl      <= `DCE_RST16;
      b_ctl      <= `DCE_RST16;
      f_ctl      <= `DCE_RST16;
      cap_ctl    <= `DCE_RST16;
      offset_reg <= `DCE_RST16;
      window_reg <= `DCE_RST16;
    end
    else if (wr_en)
    begin
      case (PADDR)
        `DCE_ADDR_ACTL:   a_ctl   <= PWDATA[15:0] & `DCE_EV_MASK;
        `DCE_ADDR_BCTL:   b_ctl   <= PWDATA[15:0] & `DCE_EV_MASK;
        `DCE_ADDR_FCTL:   f_ctl   <= PWDATA[15:0] & `DCE_FCTL_MASK;
        `DCE_ADDR_CAPCTL: cap_ctl <= PWDATA[15:0] & `DCE_CAPCTL_MASK;
        `DCE_ADDR_OFFSET: offset_reg <= PWDATA[15:0];
        `DCE_ADDR_WINDOW: window_reg <= PWDATA[15:0];
        default:          a_ctl   <= a_ctl;
      endcase
    end
  end

  // Read data is registered in the setup cycle and valid in access.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      PRDATA <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (PADDR)
        `DCE_ADDR_ACTL:   PRDATA <= {16'h0000, a_ctl};
        `DCE_ADDR_BCTL:   PRDATA <= {16'h0000, b_ctl};
        `DCE_ADDR_FCTL:   PRDATA <= {16'h0000, f_ctl};
        `DCE_ADDR_CAPCTL: PRDATA <= {16'h0000, cap_ctl};
        `DCE_ADDR_CAP:
          if (cap_ctl[`DCE_B_SHDW])
            PRDATA <= {16'h0000, cap_active};
          else
            PRDATA <= {16'h0000, cap_shadow};
        `DCE_ADDR_OFFSET: PRDATA <= {16'h0000, offset_reg};
        `DCE_ADDR_OFFCNT: PRDATA <= {16'h0000, offset_count};
        `DCE_ADDR_WINDOW: PRDATA <= {16'h0000, window_reg};
        default:          PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Reserved alignment codes select no strobe, so the timers run out and are never reloaded.
  always_comb
  begin
    case (f_ctl[`DCE_F_ALIGN_HI:`DCE_F_ALIGN_LO])
      `DCE_ALIGN_PRD:  align = PRD_STROBE;
      `DCE_ALIGN_ZERO: align = ZERO_STROBE;
      default:         align = 1'b0;
    endcase
  end

  // Filter source select.
  always_comb
  begin
    case (f_ctl[`DCE_F_SRC_HI:`DCE_F_SRC_LO])
      2'h0:    filt_src = RAW_A1;
      2'h1:    filt_src = RAW_A2;
      2'h2:    filt_src = RAW_B1;
      default: filt_src = RAW_B2;
    endcase
  end

  dce_blank_win u_blank
  (
    .clk          (MCLK),
    .rst_n        (RST_N),
    .align        (align),
    .offset       (offset_reg),
    .width        (window_reg),
    .window       (blank_win),
    .offset_count (offset_count)
  );

  // Inversion applies only while blanking is enabled at all.
  assign eff_win  = f_ctl[`DCE_B_BLANK_EN] &&
                    (blank_win ^ f_ctl[`DCE_B_BLANK_INV]);
  assign filt_evt = filt_src && !eff_win;

  // Event routing is combinational into flip-flop outputs.
  assign next_a1 = pick(a_ctl[`DCE_B_SRC1], RAW_A1, filt_evt);
  assign next_a2 = pick(a_ctl[`DCE_B_SRC2], RAW_A2, filt_evt);
  assign next_b1 = pick(b_ctl[`DCE_B_SRC1], RAW_B1, filt_evt);
  assign next_b2 = pick(b_ctl[`DCE_B_SRC2], RAW_B2, filt_evt);

  // Outputs registered, so each event shows one cycle after its input.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      COMPARE_A_EVENT_ONE <= 1'b0;
      COMPARE_A_EVENT_TWO <= 1'b0;
      COMPARE_B_EVENT_ONE <= 1'b0;
      COMPARE_B_EVENT_TWO <= 1'b0;
      FILTERED_EVENT      <= 1'b0;
      A1_SYNC_PULSE       <= 1'b0;
      A1_CONV_START       <= 1'b0;
      B1_SYNC_PULSE       <= 1'b0;
      B1_CONV_START       <= 1'b0;
    end
    else
    begin
      COMPARE_A_EVENT_ONE <= next_a1;
      COMPARE_A_EVENT_TWO <= next_a2;
      COMPARE_B_EVENT_ONE <= next_b1;
      COMPARE_B_EVENT_TWO <= next_b2;
      FILTERED_EVENT      <= filt_evt;
      A1_SYNC_PULSE       <= next_a1 && a_ctl[`DCE_B_SYNC1];
      A1_CONV_START       <= next_a1 && a_ctl[`DCE_B_SOC1];
      B1_SYNC_PULSE       <= next_b1 && b_ctl[`DCE_B_SYNC1];
      B1_CONV_START       <= next_b1 && b_ctl[`DCE_B_SOC1];
    end
  end

  // Force path selects are levels straight from the control registers.
  assign A1_ASYNC_PATH = a_ctl[`DCE_B_FRC1];
  assign A2_ASYNC_PATH = a_ctl[`DCE_B_FRC2];
  assign B1_ASYNC_PATH = b_ctl[`DCE_B_FRC1];
  assign B2_ASYNC_PATH = b_ctl[`DCE_B_FRC2];

  // Edge detect on the unregistered filtered event.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      filt_prev <= 1'b0;
    else
      filt_prev <= filt_evt;
  end

  assign cap_rise = filt_evt && !filt_prev;

  // Capture once per alignment period; the strobe re-arms and wins
  // over a rise in the same cycle, which is then not captured.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cap_active <= `DCE_RST16;
      cap_armed  <= 1'b1;
    end
    else if (align)
      cap_armed <= 1'b1;
    else if (cap_rise && cap_armed && cap_ctl[`DCE_B_CAP_EN])
    begin
      cap_active <= TIME_BASE_COUNT;
      cap_armed  <= 1'b0;
    end
  end

  // Shadow copy follows the active value at each alignment strobe while cap_ctl bit 1 is clear.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      cap_shadow <= `DCE_RST16;
    else if (align && !cap_ctl[`DCE_B_SHDW])
      cap_shadow <= cap_active;
  end
endmodule

// *** dce_checker_assertions.sv ***
// Concurrent checks on the ports of the compare event control.
// Assumes control words change only through APB writes.
`timescale 1ns/1ns
`include "dce_params.svh"
module dce_checker (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  // Events
  input wire logic        RAW_A1,
  input wire logic        RAW_B2,
  input wire logic        COMPARE_A_EVENT_ONE,
  input wire logic        COMPARE_B_EVENT_TWO,
  input wire logic        FILTERED_EVENT,
  input wire logic        A1_SYNC_PULSE,
  input wire logic        B1_CONV_START,
  input wire logic        A1_ASYNC_PATH,
  input wire logic        A2_ASYNC_PATH,
  input wire logic        B1_ASYNC_PATH,
  input wire logic        B2_ASYNC_PATH
);
  logic [15:0] actl;
  logic [15:0] bctl;
  logic [15:0] fctl;
  wire         wr = PSEL && PENABLE && PWRITE;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // Mirror the A, B and filter control words, reserved bits masked as the design must.
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      actl <= 16'h0000;
      bctl <= 16'h0000;
      fctl <= 16'h0000;
    end
    else if (wr && PADDR == `DCE_ADDR_ACTL)
      actl <= PWDATA[15:0] & `DCE_EV_MASK;
    else if (wr && PADDR == `DCE_ADDR_BCTL)
      bctl <= PWDATA[15:0] & `DCE_EV_MASK;
    else if (wr && PADDR == `DCE_ADDR_FCTL)
      fctl <= PWDATA[15:0] & `DCE_FCTL_MASK;
  end
  chk_reg_readback: assert property (
    PSEL && PENABLE && !PWRITE && PADDR == 12'h000
    |-> PRDATA == {16'h0000, actl}) else $error("control readback wrong");
  chk_unmapped_err: assert property (
    PSEL && PENABLE && PADDR > 12'h01c |-> PSLVERR)
    else $error("no error on unmapped access");
  chk_force_path: assert property (
    {A1_ASYNC_PATH, A2_ASYNC_PATH, B1_ASYNC_PATH, B2_ASYNC_PATH}
    == {actl[1], actl[9], bctl[1], bctl[9]})
    else $error("force path select wrong");
  chk_a1_raw_route: assert property (
    $past(RST_N) && !actl[0] && !$past(actl[0])
    |-> COMPARE_A_EVENT_ONE == $past(RAW_A1)) else $error("A1 route wrong");
  chk_b2_raw_route: assert property (
    $past(RST_N) && !bctl[8] && !$past(bctl[8])
    |-> COMPARE_B_EVENT_TWO == $past(RAW_B2)) else $error("B2 route wrong");
  chk_a1_sync_off: assert property (
    !actl[3] && !$past(actl[3]) |-> !A1_SYNC_PULSE)
    else $error("sync pulse while disabled");
  chk_b1_soc_off: assert property (
    !bctl[2] && !$past(bctl[2]) |-> !B1_CONV_START)
    else $error("conversion start while disabled");
  chk_filter_pass: assert property (
    $past(RST_N) && fctl[2:0] == 3'h0 && $past(fctl[2:0]) == 3'h0
    |-> FILTERED_EVENT == $past(RAW_A1)) else $error("filter path wrong");
endmodule
bind dce_event_ctrl dce_checker chk_u (.*);

// *** dce_time_base.sv ***
// Time-base counter model: up-count with period and zero strobes.
// Assumes one clock shared with the block under test.
`timescale 1ns/1ns
module dce_time_base #(
  parameter int PERIOD = 15
) (
  // Clock, reset and run control
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  // Count and strobes
  output logic      [15:0] count,
  output logic             prd,
  output logic             zero
);
  // Wraps after the period value; held at zero while stopped.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
      count <= 16'h0000;
    else if (count == 16'(PERIOD))
      count <= 16'h0000;
    else
      count <= count + 16'h0001;
  end
  // Strobes last one cycle, so the block never sees a stretched one.
  assign prd  = run && count == 16'(PERIOD);
  assign zero = run && count == 16'h0000;
endmodule

// *** dce_event_ctrl_bench.sv ***
// Self-checking bench for the compare event control.
// Assumes the time-base model supplies the count and strobes.
`timescale 1ns/1ns
module dce_event_ctrl_bench;
  localparam int PRD = 15;
  logic MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, run, slv;
  logic RAW_A1, RAW_A2, RAW_B1, RAW_B2, PRD_STROBE, ZERO_STROBE;
  logic COMPARE_A_EVENT_ONE, COMPARE_A_EVENT_TWO, FILTERED_EVENT;
  logic COMPARE_B_EVENT_ONE, COMPARE_B_EVENT_TWO;
  logic A1_ASYNC_PATH, A2_ASYNC_PATH, B1_ASYNC_PATH, B2_ASYNC_PATH;
  logic A1_SYNC_PULSE, A1_CONV_START, B1_SYNC_PULSE, B1_CONV_START;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [15:0] TIME_BASE_COUNT;
  logic [31:0] msk [4] = '{32'h030f, 32'h030f, 32'h003f, 32'h0003};
  int          err_count, samples_checked, cycles, n, s;
  dce_event_ctrl dut_u (.*);
  dce_time_base #(.PERIOD(PRD)) tb_u (
    .clk   (MCLK),
    .rst_n (RST_N),
    .run   (run),
    .count (TIME_BASE_COUNT),
    .prd   (PRD_STROBE),
    .zero  (ZERO_STROBE)
  );
  // Clock of 50 ns period.
  initial
  begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  // Watchdog cuts a hang short well beyond the expected run length.
  always @(posedge MCLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
      @(posedge MCLK);
    while (PREADY !== 1'b1);
    rd = PRDATA;
    slv = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic at_count(input int c);
    do
      @(posedge MCLK);
    while (TIME_BASE_COUNT !== 16'(c));
  endtask
  // A one-cycle raw pulse lands while the count is c plus one.
  task automatic pulse(input int c);
    at_count(c);
    RAW_A1 <= 1'b1;
    @(posedge MCLK);
    RAW_A1 <= 1'b0;
  endtask
  // Counts blanked cycles over one full period of steady state.
  task automatic blanked(input logic [31:0] f, input int exp);
    apb(1'b1, 12'h008, f);
    repeat (40) @(posedge MCLK);
    n = 0;
    repeat (PRD + 1)
    begin
      @(posedge MCLK);
      n += (FILTERED_EVENT === 1'b0);
    end
    cmp(n, exp);
  endtask
  initial
  begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    {RAW_B2, RAW_B1, RAW_A2, RAW_A1} = 4'h0;
    run = 1'b0;
    {err_count, samples_checked} = '0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    run <= 1'b1;
    for (s = 0; s < 4; s++)
    begin
      apb(1'b0, 12'(4 * s), 32'h0);
      cmp(rd, 32'h0);
      apb(1'b1, 12'(4 * s), 32'hffffffff);
      apb(1'b0, 12'(4 * s), 32'h0);
      cmp(rd, msk[s]);
      apb(1'b1, 12'(4 * s), 32'h0);
    end
    apb(1'b1, 12'h020, 32'h1234);
    cmp(slv, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    cmp({rd[31:1], ~slv}, 32'h0);
    apb(1'b1, 12'h000, 32'h020a);
    apb(1'b1, 12'h004, 32'h0204);
    RAW_A1 <= 1'b1;
    RAW_B1 <= 1'b1;
    repeat (2) @(posedge MCLK);
    cmp({A1_ASYNC_PATH, A2_ASYNC_PATH, B1_ASYNC_PATH, B2_ASYNC_PATH},
        4'b1101);
    cmp({A1_SYNC_PULSE, A1_CONV_START, COMPARE_A_EVENT_ONE}, 3'b101);
    cmp({B1_SYNC_PULSE, B1_CONV_START, COMPARE_B_EVENT_ONE}, 3'b011);
    RAW_B1 <= 1'b0;
    apb(1'b1, 12'h000, 32'h0101);
    apb(1'b1, 12'h004, 32'h0101);
    repeat (2) @(posedge MCLK);
    cmp({COMPARE_A_EVENT_ONE, COMPARE_A_EVENT_TWO, COMPARE_B_EVENT_ONE,
         COMPARE_B_EVENT_TWO}, 4'b1111);
    for (s = 0; s < 4; s++)
    begin
      apb(1'b1, 12'h008, 32'(s));
      {RAW_B2, RAW_B1, RAW_A2, RAW_A1} <= 4'(1 << s);
      repeat (2) @(posedge MCLK);
      cmp(FILTERED_EVENT, 1'b1);
      {RAW_B2, RAW_B1, RAW_A2, RAW_A1} <= ~4'(1 << s);
      repeat (2) @(posedge MCLK);
      cmp(FILTERED_EVENT, 1'b0);
    end
    {RAW_B2, RAW_B1, RAW_A2, RAW_A1} <= 4'h1;
    apb(1'b1, 12'h014, 32'h2);
    apb(1'b1, 12'h01c, 32'h3);
    blanked(32'h0004, 4);
    blanked(32'h000c, PRD + 1 - 4);
    blanked(32'h0008, 0);
    blanked(32'h0014, 4);
    // Offset 2 loads at the zero strobe; the read setup sees one step down.
    at_count(0);
    apb(1'b0, 12'h018, 32'h0);
    cmp(rd, 32'd1);
    RAW_A1 <= 1'b0;
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00c, 32'h0003);
    at_count(PRD);
    pulse(5);
    pulse(9);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rd, 32'd6);
    apb(1'b1, 12'h00c, 32'h0001);
    at_count(PRD);
    pulse(3);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rd, 32'd6);
    at_count(0);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rd, 32'd4);
    apb(1'b1, 12'h00c, 32'h0002);
    at_count(PRD);
    pulse(7);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rd, 32'd4);
    end_of_test();
  end
endmodule
